// file: logic/pps_pkg.sv
// Shared constants, types and parameter indices of the pump protection supervisor.
package pps_pkg;
	typedef logic [15:0] pps_word_t;
	typedef enum logic [1:0] {PPS_IDLE, PPS_FILL, PPS_PID} pps_fill_st_t;

	// Clock rate and the base tick of all duration timers.
	localparam int CLK_MHZ = 250;
	localparam int TICK_MS = 100;
	localparam int TICK_CYC = TICK_MS * 1000 * CLK_MHZ;
	localparam int TICKS_PER_S = 1000 / TICK_MS;
	localparam int COND_TIME_S = 40;
	localparam pps_word_t COND_TICKS = 16'(COND_TIME_S * TICKS_PER_S);

	// Parameter indices, taken from the function code numbers.
	localparam pps_word_t IDX_PB_ACTION = 16'h9600;
	localparam pps_word_t IDX_PB_LEVEL = 16'h9601;
	localparam pps_word_t IDX_PB_TIME = 16'h9602;
	localparam pps_word_t IDX_FILL_EN = 16'h9603;
	localparam pps_word_t IDX_FILL_FREQ = 16'h9604;
	localparam pps_word_t IDX_FILL_DUR = 16'h9605;
	localparam pps_word_t IDX_FILL_CUT = 16'h9606;
	localparam pps_word_t IDX_MEAS_TEMP = 16'h8932;
	localparam pps_word_t IDX_FRZ_EN = 16'h9610;
	localparam pps_word_t IDX_SENS_TYPE = 16'h9611;
	localparam pps_word_t IDX_FRZ_THR = 16'h9612;
	localparam pps_word_t IDX_PRE_THR = 16'h9613;
	localparam pps_word_t IDX_FRZ_FREQ = 16'h9614;
	localparam pps_word_t IDX_DC_CUR = 16'h9615;

	// Reset values: percent and seconds in tenths, hertz in hundredths, degrees in tenths.
	localparam pps_word_t RST_PB_ACTION = 16'h0000;
	localparam pps_word_t RST_PB_LEVEL = 16'h0064;
	localparam pps_word_t RST_PB_TIME = 16'h04b0;
	localparam pps_word_t RST_FILL_EN = 16'h0000;
	localparam pps_word_t RST_FILL_FREQ = 16'h0bb8;
	localparam pps_word_t RST_FILL_DUR = 16'h0064;
	localparam pps_word_t RST_FILL_CUT = 16'h012c;
	localparam pps_word_t RST_FRZ_EN = 16'h0000;
	localparam pps_word_t RST_SENS_TYPE = 16'h0000;
	localparam pps_word_t RST_FRZ_THR = 16'hffce;
	localparam pps_word_t RST_PRE_THR = 16'h0000;
	localparam pps_word_t RST_FRZ_FREQ = 16'h0000;
	localparam pps_word_t RST_DC_CUR = 16'h012c;

	localparam pps_word_t VAL_ON = 16'h0001;
	localparam pps_word_t SENS_MAX = 16'h0003;
	localparam pps_word_t TEMP_MIN = 16'hff38;
	localparam pps_word_t TEMP_MAX = 16'h07d0;
	localparam int NUM_DI = 8;
	localparam logic [7:0] DI_FUNC_COND = 8'h5b;
endpackage

// file: logic/pps_tmr_if.sv
// Condition, limit and expiry of one duration timer.
`timescale 1ns/1ps
interface pps_tmr_if;
	logic cond;
	logic [15:0] limit;
	logic done;
	modport owner(output cond, output limit, input done);
	modport timer(input cond, input limit, output done);
endinterface

// file: logic/pps_tick.sv
// Free-running prescaler that gives one pulse per tenth of a second.
`timescale 1ns/1ps
module pps_tick #(
	parameter int TICK_CYC = pps_pkg::TICK_CYC
) (
	input wire logic i_clk,
	input wire logic i_srst,
	output logic o_tick
);
	logic [31:0] cnt_q;

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			cnt_q <= 32'h0;
			o_tick <= 1'b0;
		end else if (cnt_q >= 32'(TICK_CYC - 1)) begin
			cnt_q <= 32'h0;
			o_tick <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 32'h1;
			o_tick <= 1'b0;
		end
	end
endmodule // pps_tick

// file: logic/pps_dur_timer.sv
// Duration timer that counts ticks while its condition holds.
`timescale 1ns/1ps
module pps_dur_timer (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_tick,
	pps_tmr_if.timer tmr
);
	logic [15:0] cnt_q;

	// A condition that drops clears the count, so time only accrues unbroken.
	always_ff @(posedge i_clk) begin
		if (i_srst || !tmr.cond) begin
			cnt_q <= 16'h0;
		end else if (i_tick && cnt_q < tmr.limit) begin
			cnt_q <= cnt_q + 16'h1;
		end
	end

	assign tmr.done = tmr.cond && (cnt_q >= tmr.limit);
endmodule // pps_dur_timer

// file: logic/pps_supervisor.sv
// Pump protection supervisor: pipe break, soft filling, freezing and condensation.
// Operation
// - Pipe break action 1 stops, 0 runs.
// - At frequency limit, persistent break stops motor.
// - Zero detection level disables pipe break check.
// - Fill enable runs filling at every start.
// - Filling runs fixed frequency for set duration.
// - Feedback reaching cutoff also ends filling early.
// - After filling, PID regulator takes frequency control.
// - Fault during filling repeats filling on restart.
// - Cold with protection enabled runs freeze frequency.
// - Freeze signal ignored during normal running.
// - Run command ends freeze run, runs normally.
// - Stop during freeze stops and disarms protection.
// - Re-arm only after temperature exceeds threshold.
// - Out-of-range temperature reads as zero.
// - Sensor type 0 invalid, 1 to 3 valid.
// - Below pre-alarm threshold asserts pre-alarm output.
// - Below freezing threshold raises freezing fault.
// - Condensation input injects DC for 40 s.
// - DC injection current is a set proportion.
`timescale 1ns/1ps
module pps_supervisor #(
	parameter int TICK_CYC = pps_pkg::TICK_CYC
) (
	input wire logic I_SYS_CLK,
	input wire logic I_SRST,
	input wire logic I_PAR_WE,
	input wire pps_pkg::pps_word_t I_PAR_IDX,
	input wire pps_pkg::pps_word_t I_PAR_WDATA,
	input wire logic I_RUN_CMD,
	input wire logic I_STOP_CMD,
	input wire logic I_FAULT_TRIP,
	input wire pps_pkg::pps_word_t I_RUN_FREQ,
	input wire pps_pkg::pps_word_t I_UPPER_FREQ_LIMIT,
	input wire pps_pkg::pps_word_t I_PID_UPPER_LIMIT,
	input wire pps_pkg::pps_word_t I_PID_FEEDBACK,
	input wire pps_pkg::pps_word_t I_TEMP_RAW,
	input wire logic [pps_pkg::NUM_DI-1:0] I_DI,
	input wire logic [pps_pkg::NUM_DI*8-1:0] I_DI_FUNC,
	output pps_pkg::pps_word_t O_PAR_RDATA,
	output logic O_STOP_REQ,
	output logic O_FIXED_RUN,
	output pps_pkg::pps_word_t O_FIXED_FREQ,
	output logic O_PID_CTRL,
	output logic O_FREEZE_ACTIVE,
	output logic O_FREEZE_FAULT,
	output logic O_PREALARM,
	output logic O_DC_INJECT,
	output pps_pkg::pps_word_t O_DC_CURRENT
);
	import pps_pkg::*;
	pps_word_t pb_action_q, pb_level_q, pb_time_q;
	pps_word_t fill_en_q, fill_freq_q, fill_dur_q, fill_cut_q;
	pps_word_t frz_en_q, sens_type_q, frz_thr_q, pre_thr_q, frz_freq_q;
	pps_word_t dc_cur_q, meas_q, rdata_q, fix_freq_q;
	pps_fill_st_t fill_st_q;
	logic run_q, pb_stop_q, armed_q, frz_q, dc_q, cond_prev_q;
	logic fix_run_q, pid_q, fault_q, pre_q;
	logic [NUM_DI-1:0] di_s1_q, di_s2_q, di_hit;
	logic tick, sens_ok, cold, warm, at_limit, pb_cond, cond_lvl, cond_rise;
	logic frz_go;
	pps_tmr_if pb_tmr();
	pps_tmr_if fill_tmr();
	pps_tmr_if dc_tmr();
	pps_tick #(.TICK_CYC(TICK_CYC)) u_tick (.i_clk(I_SYS_CLK), .i_srst(I_SRST), .o_tick(tick));
	pps_dur_timer u_pb_tmr (.i_clk(I_SYS_CLK), .i_srst(I_SRST), .i_tick(tick),
		.tmr(pb_tmr.timer));
	pps_dur_timer u_fill_tmr (.i_clk(I_SYS_CLK), .i_srst(I_SRST), .i_tick(tick),
		.tmr(fill_tmr.timer));
	pps_dur_timer u_dc_tmr (.i_clk(I_SYS_CLK), .i_srst(I_SRST), .i_tick(tick),
		.tmr(dc_tmr.timer));

	// Parameter writes; the measured temperature is read-only.
	always_ff @(posedge I_SYS_CLK) begin
		if (I_SRST) begin
			pb_action_q <= RST_PB_ACTION;
			pb_level_q <= RST_PB_LEVEL;
			pb_time_q <= RST_PB_TIME;
			fill_en_q <= RST_FILL_EN;
			fill_freq_q <= RST_FILL_FREQ;
			fill_dur_q <= RST_FILL_DUR;
			fill_cut_q <= RST_FILL_CUT;
			frz_en_q <= RST_FRZ_EN;
			sens_type_q <= RST_SENS_TYPE;
			frz_thr_q <= RST_FRZ_THR;
			pre_thr_q <= RST_PRE_THR;
			frz_freq_q <= RST_FRZ_FREQ;
			dc_cur_q <= RST_DC_CUR;
		end else if (I_PAR_WE) begin
			if (I_PAR_IDX == IDX_PB_ACTION) begin
				pb_action_q <= I_PAR_WDATA;
			end else if (I_PAR_IDX == IDX_PB_LEVEL) begin
				pb_level_q <= I_PAR_WDATA;
			end else if (I_PAR_IDX == IDX_PB_TIME) begin
				pb_time_q <= I_PAR_WDATA;
			end else if (I_PAR_IDX == IDX_FILL_EN) begin
				fill_en_q <= I_PAR_WDATA;
			end else if (I_PAR_IDX == IDX_FILL_FREQ) begin
				fill_freq_q <= I_PAR_WDATA;
			end else if (I_PAR_IDX == IDX_FILL_DUR) begin
				fill_dur_q <= I_PAR_WDATA;
			end else if (I_PAR_IDX == IDX_FILL_CUT) begin
				fill_cut_q <= I_PAR_WDATA;
			end else if (I_PAR_IDX == IDX_FRZ_EN) begin
				frz_en_q <= I_PAR_WDATA;
			end else if (I_PAR_IDX == IDX_SENS_TYPE) begin
				sens_type_q <= I_PAR_WDATA;
			end else if (I_PAR_IDX == IDX_FRZ_THR) begin
				frz_thr_q <= I_PAR_WDATA;
			end else if (I_PAR_IDX == IDX_PRE_THR) begin
				pre_thr_q <= I_PAR_WDATA;
			end else if (I_PAR_IDX == IDX_FRZ_FREQ) begin
				frz_freq_q <= I_PAR_WDATA;
			end else if (I_PAR_IDX == IDX_DC_CUR) begin
				dc_cur_q <= I_PAR_WDATA;
			end
		end
	end

	// Read data follows the index one cycle later; unknown indices read zero.
	always_ff @(posedge I_SYS_CLK) begin
		if (I_SRST) begin
			rdata_q <= 16'h0;
		end else if (I_PAR_IDX == IDX_PB_ACTION) begin
			rdata_q <= pb_action_q;
		end else if (I_PAR_IDX == IDX_PB_LEVEL) begin
			rdata_q <= pb_level_q;
		end else if (I_PAR_IDX == IDX_PB_TIME) begin
			rdata_q <= pb_time_q;
		end else if (I_PAR_IDX == IDX_FILL_EN) begin
			rdata_q <= fill_en_q;
		end else if (I_PAR_IDX == IDX_FILL_FREQ) begin
			rdata_q <= fill_freq_q;
		end else if (I_PAR_IDX == IDX_FILL_DUR) begin
			rdata_q <= fill_dur_q;
		end else if (I_PAR_IDX == IDX_FILL_CUT) begin
			rdata_q <= fill_cut_q;
		end else if (I_PAR_IDX == IDX_MEAS_TEMP) begin
			rdata_q <= meas_q;
		end else if (I_PAR_IDX == IDX_FRZ_EN) begin
			rdata_q <= frz_en_q;
		end else if (I_PAR_IDX == IDX_SENS_TYPE) begin
			rdata_q <= sens_type_q;
		end else if (I_PAR_IDX == IDX_FRZ_THR) begin
			rdata_q <= frz_thr_q;
		end else if (I_PAR_IDX == IDX_PRE_THR) begin
			rdata_q <= pre_thr_q;
		end else if (I_PAR_IDX == IDX_FRZ_FREQ) begin
			rdata_q <= frz_freq_q;
		end else if (I_PAR_IDX == IDX_DC_CUR) begin
			rdata_q <= dc_cur_q;
		end else begin
			rdata_q <= 16'h0;
		end
	end

	// Temperature outside the measuring span is shown as zero.
	always_ff @(posedge I_SYS_CLK) begin
		if (I_SRST) begin
			meas_q <= 16'h0;
		end else if ($signed(I_TEMP_RAW) < $signed(TEMP_MIN) ||
				$signed(I_TEMP_RAW) > $signed(TEMP_MAX)) begin
			meas_q <= 16'h0;
		end else begin
			meas_q <= I_TEMP_RAW;
		end
	end

	assign sens_ok = (sens_type_q != 16'h0) && (sens_type_q <= SENS_MAX);
	assign cold = sens_ok && ($signed(meas_q) < $signed(frz_thr_q));
	assign warm = sens_ok && ($signed(meas_q) > $signed(frz_thr_q));

	// Normal run state, ended by stop, trip or a pipe break stop.
	always_ff @(posedge I_SYS_CLK) begin
		if (I_SRST) begin
			run_q <= 1'b0;
		end else if (I_STOP_CMD || I_FAULT_TRIP || pb_tmr.done) begin
			run_q <= 1'b0;
		end else if (I_RUN_CMD) begin
			run_q <= 1'b1;
		end
	end

	// Pipe break: pinned at a frequency limit while feedback stays under level.
	assign at_limit = (I_RUN_FREQ >= I_UPPER_FREQ_LIMIT) || (I_RUN_FREQ >= I_PID_UPPER_LIMIT);
	assign pb_cond = (pb_action_q == VAL_ON) && (pb_level_q != 16'h0) && run_q &&
		at_limit && (I_PID_FEEDBACK < pb_level_q);
	assign pb_tmr.cond = pb_cond;
	assign pb_tmr.limit = pb_time_q;

	// A new start releases the stop request, but a break seen in that cycle wins.
	always_ff @(posedge I_SYS_CLK) begin
		if (I_SRST) begin
			pb_stop_q <= 1'b0;
		end else if (pb_tmr.done) begin
			pb_stop_q <= 1'b1;
		end else if (I_RUN_CMD) begin
			pb_stop_q <= 1'b0;
		end
	end

	// Soft filling sequence at every start.
	always_ff @(posedge I_SYS_CLK) begin
		if (I_SRST) begin
			fill_st_q <= PPS_IDLE;
		end else begin
			case (fill_st_q)
				PPS_IDLE: begin
					if (I_RUN_CMD && !I_STOP_CMD && !I_FAULT_TRIP) begin
						fill_st_q <= (fill_en_q == VAL_ON) ? PPS_FILL : PPS_PID;
					end
				end
				PPS_FILL: begin
					if (I_STOP_CMD || I_FAULT_TRIP || pb_tmr.done) begin
						fill_st_q <= PPS_IDLE;
					end else if (fill_tmr.done || I_PID_FEEDBACK >= fill_cut_q) begin
						fill_st_q <= PPS_PID;
					end
				end
				PPS_PID: begin
					if (I_STOP_CMD || I_FAULT_TRIP || pb_tmr.done) begin
						fill_st_q <= PPS_IDLE;
					end
				end
				default: begin
					fill_st_q <= PPS_IDLE;
				end
			endcase
		end
	end

	assign fill_tmr.cond = (fill_st_q == PPS_FILL) && (I_RUN_FREQ == fill_freq_q);
	assign fill_tmr.limit = fill_dur_q;

	// Automatic freezing protection.
	assign frz_go = (frz_en_q == VAL_ON) && armed_q && cold && !run_q;

	always_ff @(posedge I_SYS_CLK) begin
		if (I_SRST) begin
			frz_q <= 1'b0;
		end else if (I_RUN_CMD || I_STOP_CMD || I_FAULT_TRIP) begin
			frz_q <= 1'b0;
		end else begin
			frz_q <= frz_go;
		end
	end

	always_ff @(posedge I_SYS_CLK) begin
		if (I_SRST) begin
			armed_q <= 1'b1;
		end else if (frz_q && I_STOP_CMD) begin
			armed_q <= 1'b0;
		end else if (warm) begin
			armed_q <= 1'b1;
		end
	end

	// Fixed-frequency run requests and hand-over to the PID regulator.
	always_ff @(posedge I_SYS_CLK) begin
		if (I_SRST) begin
			fix_run_q <= 1'b0;
			fix_freq_q <= 16'h0;
			pid_q <= 1'b0;
		end else if (fill_st_q == PPS_FILL) begin
			fix_run_q <= 1'b1;
			fix_freq_q <= fill_freq_q;
			pid_q <= 1'b0;
		end else if (frz_q) begin
			fix_run_q <= 1'b1;
			fix_freq_q <= frz_freq_q;
			pid_q <= 1'b0;
		end else begin
			fix_run_q <= 1'b0;
			fix_freq_q <= 16'h0;
			pid_q <= (fill_st_q == PPS_PID);
		end
	end

	always_ff @(posedge I_SYS_CLK) begin
		if (I_SRST) begin
			fault_q <= 1'b0;
			pre_q <= 1'b0;
		end else begin
			fault_q <= (frz_en_q == VAL_ON) && cold;
			pre_q <= sens_ok && ($signed(meas_q) < $signed(pre_thr_q));
		end
	end

	// Condensation terminals pass a two-stage synchroniser before use.
	always_ff @(posedge I_SYS_CLK) begin
		if (I_SRST) begin
			di_s1_q <= '0;
			di_s2_q <= '0;
		end else begin
			di_s1_q <= I_DI;
			di_s2_q <= di_s1_q;
		end
	end

	generate
		for (genvar g = 0; g < NUM_DI; g++) begin : g_di
			assign di_hit[g] = di_s2_q[g] && (I_DI_FUNC[g*8 +: 8] == DI_FUNC_COND);
		end
	endgenerate

	assign cond_lvl = |di_hit;
	assign cond_rise = cond_lvl && !cond_prev_q;

	always_ff @(posedge I_SYS_CLK) begin
		if (I_SRST) begin
			cond_prev_q <= 1'b0;
			dc_q <= 1'b0;
		end else begin
			cond_prev_q <= cond_lvl;
			if (cond_rise) begin
				dc_q <= 1'b1;
			end else if (dc_tmr.done) begin
				dc_q <= 1'b0;
			end
		end
	end
	assign dc_tmr.cond = dc_q;
	assign dc_tmr.limit = COND_TICKS;
	assign O_PAR_RDATA = rdata_q;
	assign O_STOP_REQ = pb_stop_q;
	assign O_FIXED_RUN = fix_run_q;
	assign O_FIXED_FREQ = fix_freq_q;
	assign O_PID_CTRL = pid_q;
	assign O_FREEZE_ACTIVE = frz_q;
	assign O_FREEZE_FAULT = fault_q;
	assign O_PREALARM = pre_q;
	assign O_DC_INJECT = dc_q;
	assign O_DC_CURRENT = dc_cur_q;
	default clocking cb @(posedge I_SYS_CLK); endclocking
	default disable iff (I_SRST);
	pb_action_off_a: assert property ((pb_action_q != VAL_ON && !O_STOP_REQ) |=> !O_STOP_REQ)
		else $error("Pipe break stop raised while action is not stop.");
	pb_stop_a: assert property (pb_tmr.done |=> O_STOP_REQ && !run_q)
		else $error("Pipe break expiry did not stop the motor.");
	pb_level_off_a: assert property ((pb_level_q == 16'h0 && !O_STOP_REQ) |=> !O_STOP_REQ)
		else $error("Pipe break stop raised with zero level.");
	fill_start_a: assert property ((fill_st_q == PPS_IDLE && I_RUN_CMD && !I_STOP_CMD
		&& !I_FAULT_TRIP && fill_en_q == VAL_ON) |=> fill_st_q == PPS_FILL ##1 O_FIXED_RUN)
		else $error("Start did not enter soft filling.");
	fill_freq_a: assert property ((fill_st_q == PPS_FILL) |=> O_FIXED_FREQ == $past(fill_freq_q))
		else $error("Filling frequency not requested.");
	fill_cut_a: assert property ((fill_st_q == PPS_FILL && !I_STOP_CMD && !I_FAULT_TRIP
		&& !pb_tmr.done && I_PID_FEEDBACK >= fill_cut_q) |=> fill_st_q == PPS_PID ##1 O_PID_CTRL)
		else $error("Cutoff feedback did not hand over to PID.");
	fill_refill_a: assert property ((fill_st_q == PPS_FILL && I_FAULT_TRIP) |=> fill_st_q == PPS_IDLE)
		else $error("Fault during filling not returned to idle.");
	frz_ignore_a: assert property (run_q |=> !frz_q)
		else $error("Freeze run active under a normal run.");
	frz_disarm_a: assert property ((frz_q && I_STOP_CMD) |=> !frz_q && !armed_q)
		else $error("Stop did not disarm freezing protection.");
	temp_range_a: assert property (($signed(I_TEMP_RAW) > $signed(TEMP_MAX)) |=> meas_q == 16'h0)
		else $error("Out-of-range temperature not shown as zero.");
	dc_hold_a: assert property ($rose(dc_q) |-> dc_q [*8])
		else $error("DC injection ended too early.");
	dc_edge_a: assert property ((cond_lvl && $past(cond_lvl) && !dc_q) |=> !dc_q)
		else $error("Held condensation level retriggered injection.");
	fill_pid_c: cover property (fill_st_q == PPS_FILL ##[1:300] fill_st_q == PPS_PID);
	frz_run_c: cover property (frz_q ##1 I_RUN_CMD ##1 run_q);
	pb_stop_c: cover property ($rose(pb_stop_q));
	dc_c: cover property ($fell(dc_q));
endmodule // pps_supervisor

// file: dv/pps_plant.sv
// Pump motor and condensation sensor model on the far side of the supervisor.
`timescale 1ns/1ps
module pps_plant (
	input wire logic i_fixed_run,
	input wire pps_pkg::pps_word_t i_fixed_freq,
	input wire logic i_pid_ctrl,
	input wire pps_pkg::pps_word_t i_pid_freq,
	input wire logic i_slip,
	input wire logic i_cond,
	output pps_pkg::pps_word_t o_run_freq,
	output logic [7:0] o_di
);
	import pps_pkg::*;
	// A slipping motor settles one step below the fixed frequency that it was given.
	always_comb begin
		if (i_fixed_run) begin
			o_run_freq = i_fixed_freq - {15'h0, i_slip};
		end else if (i_pid_ctrl) begin
			o_run_freq = i_pid_freq;
		end else begin
			o_run_freq = 16'h0;
		end
	end
	// The sensor on terminal 3 repeats only by releasing and asserting again.
	assign o_di = {4'h0, i_cond, 3'h0};
endmodule // pps_plant

// file: dv/pps_supervisor_tb.sv
// Self-checking bench of the pump protection supervisor against a behavioural model.
`timescale 1ns/1ps
module pps_supervisor_tb;
	import pps_pkg::*;
	localparam int TCYC = 10;
	localparam int S_STOP = 0, S_FRUN = 1, S_PID = 2, S_FRZ = 3, S_DC = 4;
	logic clk, srst, we, run, stp, trip, slip, cond, pb;
	pps_word_t idx, wdata, pid_freq, upper, pid_up, fb, temp, cold, run_freq, o_rdata, o_ffreq;
	pps_word_t o_dccur;
	logic [63:0] di_func;
	logic [7:0] di;
	logic o_stop, o_frun, o_pid, o_frz, o_fault, o_pre, o_dc;
	logic [4:0] outs;
	int n_errors, samples_checked, k, seed;
	int mreg[pps_word_t];
	pps_word_t ids[13] = '{IDX_PB_ACTION, IDX_PB_LEVEL, IDX_PB_TIME, IDX_FILL_EN, IDX_FILL_FREQ,
		IDX_FILL_DUR, IDX_FILL_CUT, IDX_FRZ_EN, IDX_SENS_TYPE, IDX_FRZ_THR, IDX_PRE_THR,
		IDX_FRZ_FREQ, IDX_DC_CUR};
	pps_word_t rsts[13] = '{RST_PB_ACTION, RST_PB_LEVEL, RST_PB_TIME, RST_FILL_EN, RST_FILL_FREQ,
		RST_FILL_DUR, RST_FILL_CUT, RST_FRZ_EN, RST_SENS_TYPE, RST_FRZ_THR, RST_PRE_THR,
		RST_FRZ_FREQ, RST_DC_CUR};
	pps_word_t temps[5] = '{16'h07d1, 16'hff37, 16'hff38, 16'h07d0, 16'hffec};
	assign outs = {o_dc, o_frz, o_pid, o_frun, o_stop};

	pps_supervisor #(.TICK_CYC(TCYC)) dut_u (.I_SYS_CLK(clk), .I_SRST(srst), .I_PAR_WE(we),
		.I_PAR_IDX(idx), .I_PAR_WDATA(wdata), .I_RUN_CMD(run), .I_STOP_CMD(stp),
		.I_FAULT_TRIP(trip), .I_RUN_FREQ(run_freq), .I_UPPER_FREQ_LIMIT(upper),
		.I_PID_UPPER_LIMIT(pid_up), .I_PID_FEEDBACK(fb), .I_TEMP_RAW(temp), .I_DI(di),
		.I_DI_FUNC(di_func), .O_PAR_RDATA(o_rdata), .O_STOP_REQ(o_stop), .O_FIXED_RUN(o_frun),
		.O_FIXED_FREQ(o_ffreq), .O_PID_CTRL(o_pid), .O_FREEZE_ACTIVE(o_frz),
		.O_FREEZE_FAULT(o_fault), .O_PREALARM(o_pre), .O_DC_INJECT(o_dc),
		.O_DC_CURRENT(o_dccur));
	pps_plant plant_u (.i_fixed_run(o_frun), .i_fixed_freq(o_ffreq), .i_pid_ctrl(o_pid),
		.i_pid_freq(pid_freq), .i_slip(slip), .i_cond(cond), .o_run_freq(run_freq), .o_di(di));

	task automatic chk_w(input pps_word_t got, input pps_word_t exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_b(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	function automatic int meas(input pps_word_t v);
		return ($signed(v) < -200 || $signed(v) > 2000) ? 0 : int'(v);
	endfunction
	function automatic logic below(input pps_word_t thr_idx);
		return $signed(16'(mreg[IDX_MEAS_TEMP])) < $signed(16'(mreg[thr_idx]))
			&& mreg[IDX_SENS_TYPE] inside {[1:3]};
	endfunction
	task automatic wr(input pps_word_t i, input pps_word_t v);
		@(posedge clk);
		we <= 1'b1;
		idx <= i;
		wdata <= v;
		@(posedge clk);
		we <= 1'b0;
		foreach (ids[j]) begin
			if (ids[j] == i) mreg[i] = int'(v);
		end
	endtask
	task automatic rd_chk(input pps_word_t i);
		@(posedge clk);
		idx <= i;
		repeat (2) @(posedge clk);
		#1;
		chk_w(o_rdata, mreg.exists(i) ? 16'(mreg[i]) : 16'h0);
	endtask
	task automatic cmd(input int c);
		@(posedge clk);
		run <= (c == 0);
		stp <= (c == 1);
		trip <= (c == 2);
		@(posedge clk);
		run <= 1'b0;
		stp <= 1'b0;
		trip <= 1'b0;
	endtask
	task automatic set_temp(input pps_word_t v);
		@(posedge clk);
		temp <= v;
		mreg[IDX_MEAS_TEMP] = meas(v);
	endtask
	task automatic wait_b(input int s, input logic v, input int lim, output int n);
		n = 0;
		#1;
		while (outs[s] !== v && n < lim) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk_b(outs[s], v);
	endtask
	task automatic results();
		$display("Comparisons %0d, mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		#200000;
		n_errors++;
		results();
	end
	initial begin
		{srst, we, run, stp, trip, slip, cond} = 7'h40;
		{idx, wdata, pid_freq, fb} = '0;
		{upper, pid_up, temp} = {16'd5000, 16'd6000, 16'd200};
		seed = $urandom(32'h8abd);
		di_func = {32'($urandom), DI_FUNC_COND, 24'($urandom)};
		foreach (ids[i]) mreg[ids[i]] = int'(rsts[i]);
		mreg[IDX_MEAS_TEMP] = meas(temp);
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		foreach (ids[i]) rd_chk(ids[i]);
		foreach (ids[i]) begin
			wr(ids[i], 16'($urandom));
			rd_chk(ids[i]);
			chk_w(o_dccur, 16'(mreg[IDX_DC_CUR]));
			wr(ids[i], rsts[i]);
		end
		wr(16'h9607, 16'h1234);
		rd_chk(16'h9607);
		wr(IDX_MEAS_TEMP, 16'h0055);
		rd_chk(IDX_MEAS_TEMP);
		foreach (temps[i]) begin
			set_temp(i == 4 ? 16'(-200 + $urandom_range(2200)) : temps[i]);
			rd_chk(IDX_MEAS_TEMP);
		end
		// Filling by time, with a slip in the middle that must restart the count.
		wr(IDX_FILL_EN, VAL_ON);
		wr(IDX_FILL_DUR, 16'h0005);
		cmd(0);
		wait_b(S_FRUN, 1'b1, 5, k);
		chk_w(o_ffreq, 16'(mreg[IDX_FILL_FREQ]));
		repeat (30) @(posedge clk);
		slip <= 1'b1;
		repeat (20) @(posedge clk);
		slip <= 1'b0;
		wait_b(S_PID, 1'b1, 100, k);
		chk_b(k >= 38 && k <= 70, 1'b1);
		chk_b(o_frun, 1'b0);
		cmd(1);
		cmd(0);
		wait_b(S_FRUN, 1'b1, 5, k);
		cmd(2);
		wait_b(S_FRUN, 1'b0, 5, k);
		cmd(0);
		wait_b(S_FRUN, 1'b1, 5, k);
		@(posedge clk);
		fb <= 16'(mreg[IDX_FILL_CUT]);
		wait_b(S_PID, 1'b1, 6, k);
		chk_b(o_frun, 1'b0);
		cmd(1);
		fb <= 16'd50;
		pid_freq <= 16'd5000;
		wr(IDX_FILL_EN, 16'h0000);
		wr(IDX_PB_TIME, 16'h0003);
		for (int c = 0; c < 3; c++) begin
			wr(IDX_PB_ACTION, c == 1 ? 16'h0000 : VAL_ON);
			wr(IDX_PB_LEVEL, c == 2 ? 16'h0000 : 16'h0064);
			pb = mreg[IDX_PB_ACTION] == 1 && mreg[IDX_PB_LEVEL] != 0;
			cmd(0);
			if (!pb) repeat (60) @(posedge clk);
			wait_b(S_STOP, pb, 80, k);
			if (pb) chk_b(k >= 18 && k <= 50, 1'b1);
			cmd(1);
		end
		// Freezing: start, run over it, stop to disarm, warm up to re-arm.
		cold = 16'(-51 - int'($urandom_range(149)));
		wr(IDX_SENS_TYPE, 16'h0001);
		wr(IDX_FRZ_FREQ, 16'h03e8);
		set_temp(cold);
		wr(IDX_FRZ_EN, VAL_ON);
		wait_b(S_FRZ, 1'b1, 10, k);
		repeat (2) @(posedge clk);
		#1;
		chk_w(o_ffreq, 16'(mreg[IDX_FRZ_FREQ]));
		cmd(0);
		wait_b(S_FRZ, 1'b0, 5, k);
		wait_b(S_PID, 1'b1, 5, k);
		repeat (20) @(posedge clk);
		wait_b(S_FRZ, 1'b0, 0, k);
		cmd(1);
		wait_b(S_FRZ, 1'b1, 10, k);
		cmd(1);
		repeat (30) @(posedge clk);
		wait_b(S_FRZ, 1'b0, 0, k);
		set_temp(16'(mreg[IDX_FRZ_THR]));
		repeat (10) @(posedge clk);
		set_temp(cold);
		repeat (10) @(posedge clk);
		wait_b(S_FRZ, 1'b0, 0, k);
		set_temp(16'd100);
		repeat (10) @(posedge clk);
		set_temp(cold);
		wait_b(S_FRZ, 1'b1, 10, k);
		for (int s = 0; s < 4; s++) begin
			wr(IDX_SENS_TYPE, 16'(s));
			set_temp(s[0] ? 16'hffec : cold);
			repeat (3) @(posedge clk);
			#1;
			chk_b(o_fault, mreg[IDX_FRZ_EN] == 1 && below(IDX_FRZ_THR));
			chk_b(o_pre, below(IDX_PRE_THR));
		end
		cmd(1);
		wr(IDX_FRZ_EN, 16'h0000);
		// Condensation: full length, no retrigger on a held level, rise in mid-run ignored.
		@(posedge clk);
		cond <= 1'b1;
		wait_b(S_DC, 1'b1, 6, k);
		wait_b(S_DC, 1'b0, 5000, k);
		chk_b(k >= COND_TICKS * TCYC - 12 && k <= COND_TICKS * TCYC + 2, 1'b1);
		repeat (50) @(posedge clk);
		wait_b(S_DC, 1'b0, 0, k);
		@(posedge clk);
		cond <= 1'b0;
		repeat (5) @(posedge clk);
		cond <= 1'b1;
		wait_b(S_DC, 1'b1, 6, k);
		repeat (100) @(posedge clk);
		cond <= 1'b0;
		repeat (10) @(posedge clk);
		cond <= 1'b1;
		wait_b(S_DC, 1'b0, 5000, k);
		chk_b(k + 110 >= COND_TICKS * TCYC - 12 && k + 110 <= COND_TICKS * TCYC + 2, 1'b1);
		results();
	end
endmodule // pps_supervisor_tb
